/* src/wdfs_map.svh */
// Register offsets, field positions, reset values and timing counts of the watchdog supervisor.
`ifndef WDFS_MAP_SVH
`define WDFS_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the APB)
// ----------------------------------------------------------------------------
`define WDFS_CFG_OFS   8'h00
`define WDFS_CMD_OFS   8'h04
`define WDFS_SEL_OFS   8'h08
`define WDFS_OLC_OFS   8'h0c
`define WDFS_OCC_OFS   8'h10
`define WDFS_STAT_OFS  8'h14
`define WDFS_MODE_OFS  8'h18

// ----------------------------------------------------------------------------
// Field positions and sizes
// ----------------------------------------------------------------------------
`define WDFS_TOG_BIT   15
`define WDFS_DIV_HI    5
`define WDFS_DIV_LO    4
`define WDFS_NOUT      12
`define WDFS_NHS       4
`define WDFS_FS_ON     12'h005
`define WDFS_CFG_RST   16'h0000
`define WDFS_OUT_RST   12'h000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDFS_CLK_MHZ   20
`define WDFS_BASE_TO_US 10000
`define WDFS_FILT_US   10
`define WDFS_FILT_W    8

`endif

/* src/wdfs_pkg.sv */
// Types shared by the watchdog and fail-safe supervisor.
package wdfs_pkg;

  // Operating mode derived from the wake and reset pins and the watchdog.
  typedef enum logic [1:0] {
    WDFS_SLEEP,
    WDFS_HOLD,
    WDFS_NORMAL,
    WDFS_FAILSAFE
  } wdfs_mode_t;

endpackage

/* src/wdfs_top.sv */
// Watchdog, fail-safe forcing, mode table and per-output fault supervisor with an APB slave.
`include "wdfs_map.svh"

// Summary of operation
// [R1] Wake or reset rising edge starts watchdog.
// [R2] Pin or message bit toggle refreshes watchdog.
// [R3] Timeout without refresh latches fail-safe mode.
// [R4] Fail-safe drives outputs zero, two on only.
// [R5] Wake and reset low leave fail-safe.
// [R6] Fail-safe disable input low disables everything; the code clears only the watchdog enable and fail-safe, outputs still run.
// [R7] Wake and reset low: sleep, outputs off.
// [R8] Reset low: outputs off, default after.
// [R9] Reset high: outputs follow configuration, inputs.
// [R10] Reset clears all configuration bits to zero.
// [R11] Default: low sides shared input, highs own.
// [R12] Default: high-side open load on, low off.
// [R13] Faults per output; overvoltage global; overcurrent low.
// [R14] Low-side overcurrent, open load pass filter.
// [R15] Faults latch; cleared on chip select rise.
// [R16] Flag pin real time for global, high.
// [R17] Low-side flag latches until toggle, reset.
// [R18] Overtemperature only while on, local shutdown.
// [R19] Low-side overtemperature off until commanded off.
// [R20] High-side overtemperature restarts after cooling.
// [R21] Overvoltage: all off, all bits latched.
// [R22] Divider field halves timeout per step.
// [R23] Status bits eleven..four low, three..zero high.
// [R24] Counter restarts on refresh and divider change.
module wdfs_top
  import wdfs_pkg::*;
#(
  parameter int unsigned BASE_TO_CYC = `WDFS_BASE_TO_US * `WDFS_CLK_MHZ
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode pins.
  input  wire logic        wake_in,
  input  wire logic        reset_pin_n,
  input  wire logic        watchdog_refresh_pin,
  input  wire logic        failsafe_disable_input,
  input  wire logic        chip_select_n,
  // Direct inputs.
  input  wire logic        low_side_direct_input,
  input  wire logic [3:0]  high_side_direct_input,
  // Fault sensors.
  input  wire logic        overvoltage_sense,
  input  wire logic [11:0] overtemp_sense,
  input  wire logic [11:0] open_load_sense,
  input  wire logic [7:0]  overcurrent_sense,
  // Outputs.
  output logic      [11:0] output_on,
  output logic             fault_flag_pin_n,
  output logic             failsafe_active
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  localparam int PW = 43;
  localparam logic [`WDFS_FILT_W-1:0] FILT_CYC = `WDFS_FILT_W'(`WDFS_FILT_US * `WDFS_CLK_MHZ);
  localparam logic [PW-1:0] SYNC_RST = {4'h0, 1'b1, 38'h0}; // Select idles high: no false rise after reset.

  logic [PW-1:0] pin_raw;
  logic [PW-1:0] sync1_ff;
  logic [PW-1:0] sync2_ff;
  logic [3:0]    prev_ff;
  logic          wake_s, rstp_s, watchdog_refresh_pin_s, fsi_s, cs_s, ils_s, ov_s;
  logic [3:0]    ihs_s;
  logic [11:0]   ot_s, ol_s;
  logic [7:0]    oc_s;

  assign pin_raw = {wake_in, reset_pin_n, watchdog_refresh_pin, failsafe_disable_input, chip_select_n,
                    low_side_direct_input, high_side_direct_input, overvoltage_sense, overtemp_sense,
                    open_load_sense, overcurrent_sense};

  // Every pin passes two flops; only the second stage is read by logic.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  assign {wake_s, rstp_s, watchdog_refresh_pin_s, fsi_s, cs_s, ils_s, ihs_s, ov_s, ot_s, ol_s, oc_s} = sync2_ff;

  // Previous levels for edge detection on the mode and strobe pins.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 4'h1;
    end else begin
      prev_ff <= {wake_s, rstp_s, watchdog_refresh_pin_s, cs_s};
    end
  end

  logic wake_rise, rst_rise, watchdog_refresh_pin_edge, cs_rise;
  assign wake_rise = wake_s & ~prev_ff[3];
  assign rst_rise  = rstp_s & ~prev_ff[2];
  assign watchdog_refresh_pin_edge = watchdog_refresh_pin_s ^ prev_ff[1];
  assign cs_rise   = cs_s & ~prev_ff[0];

  // --------------------------------------------------------------------------
  // APB slave and configuration registers
  // --------------------------------------------------------------------------
  logic [15:0] cfg_ff;
  logic [11:0] cmd_ff, sel_ff, olc_ff, occ_ff;
  logic [11:0] stat_ff, out_ff;
  logic [31:0] prdata_ff, rd_data;
  logic        pready_ff, pslverr_ff, rd_hit;
  logic        setup, wr, wd_en_ff, fs_ff, flag_n_ff, expired;
  wdfs_mode_t  mode_ff, nxt_mode;
  logic [2:0]  echo_bits;

  assign setup = psel & ~penable;
  assign wr    = psel & penable & pready_ff & pwrite;

  // The echo bits follow the last toggle bit, as in the serial status word.
  assign echo_bits = cfg_ff[`WDFS_TOG_BIT] ? {ihs_s[2], ihs_s[3], wake_s} : {ihs_s[0], ihs_s[1], fsi_s};

  // Read decode; unaligned or unmapped addresses answer with an error.
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      `WDFS_CFG_OFS:  rd_data = {16'h0000, cfg_ff};
      `WDFS_CMD_OFS:  rd_data = {20'h00000, cmd_ff};
      `WDFS_SEL_OFS:  rd_data = {20'h00000, sel_ff};
      `WDFS_OLC_OFS:  rd_data = {20'h00000, olc_ff};
      `WDFS_OCC_OFS:  rd_data = {20'h00000, occ_ff};
      `WDFS_STAT_OFS: rd_data = {16'h0000, cfg_ff[`WDFS_TOG_BIT], echo_bits, stat_ff}; // R23
      `WDFS_MODE_OFS: rd_data = {26'h0000000, flag_n_ff, expired, wd_en_ff, fs_ff, mode_ff};
      default:        rd_hit  = 1'b0;
    endcase
  end

  // Zero-wait answer: the setup cycle prepares data, so pready is high in the first access cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~rd_hit;
      prdata_ff  <= (setup & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // Configuration is held at zero while the reset pin is low.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= `WDFS_CFG_RST;
      cmd_ff <= `WDFS_OUT_RST;
      sel_ff <= `WDFS_OUT_RST;
      olc_ff <= `WDFS_OUT_RST;
      occ_ff <= `WDFS_OUT_RST;
    end else if (!rstp_s) begin // R10
      cfg_ff <= `WDFS_CFG_RST;
      cmd_ff <= `WDFS_OUT_RST;
      sel_ff <= `WDFS_OUT_RST;
      olc_ff <= `WDFS_OUT_RST;
      occ_ff <= `WDFS_OUT_RST;
    end else if (wr) begin
      if (paddr == `WDFS_CFG_OFS) cfg_ff <= pwdata[15:0];
      if (paddr == `WDFS_CMD_OFS) cmd_ff <= pwdata[11:0];
      if (paddr == `WDFS_SEL_OFS) sel_ff <= pwdata[11:0];
      if (paddr == `WDFS_OLC_OFS) olc_ff <= pwdata[11:0];
      if (paddr == `WDFS_OCC_OFS) occ_ff <= {pwdata[11:4], 4'h0};
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------------
  logic [31:0] wd_cnt_ff, wd_limit;
  logic        wd_start, wd_refresh, cfg_wr, wake_seen_ff, fs_exit, sleep_pins;

  assign cfg_wr     = wr & (paddr == `WDFS_CFG_OFS);
  assign wd_start   = wake_rise | rst_rise; // R1
  // A toggle of the pin or of the message bit refreshes; a divider change restarts the count.
  assign wd_refresh = watchdog_refresh_pin_edge | (cfg_wr & (pwdata[`WDFS_TOG_BIT] ^ cfg_ff[`WDFS_TOG_BIT])) // R2
                    | (cfg_wr & (pwdata[5:4] != cfg_ff[`WDFS_DIV_HI:`WDFS_DIV_LO])); // R24
  assign wd_limit   = 32'(BASE_TO_CYC) >> cfg_ff[`WDFS_DIV_HI:`WDFS_DIV_LO]; // R22
  assign expired    = wd_en_ff & (wd_cnt_ff >= wd_limit);
  assign sleep_pins = ~wake_s & ~rstp_s;
  // Without a wake rise the reset pin alone releases fail-safe.
  assign fs_exit    = fs_ff & ~rstp_s & (~wake_s | ~wake_seen_ff); // R5

  // Watchdog enable; the disable input tied low keeps it off for good.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_en_ff <= 1'b0;
    end else if (!fsi_s || sleep_pins || fs_exit) begin // R6
      wd_en_ff <= 1'b0;
    end else if (wd_start) begin // R1
      wd_en_ff <= 1'b1;
    end
  end

  // The count stops at the limit so that expiry stays visible.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_ff <= 32'h0000_0000;
    end else if (wd_start || wd_refresh || !wd_en_ff) begin // R24
      wd_cnt_ff <= 32'h0000_0000;
    end else if (!expired) begin
      wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
    end
  end

  // Remembers whether wake was raised since the last sleep.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_seen_ff <= 1'b0;
    end else if (wake_s) begin
      wake_seen_ff <= 1'b1;
    end else if (!rstp_s) begin
      wake_seen_ff <= 1'b0;
    end
  end

  // Fail-safe latch; reinitialisation wins, as it also stops the watchdog.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fs_ff <= 1'b0;
    end else if (!fsi_s || fs_exit) begin // R5 R6
      fs_ff <= 1'b0;
    end else if (expired) begin // R3
      fs_ff <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Per-output command and fault logic
  // --------------------------------------------------------------------------
  logic [11:0] cmd_on, dir_on, norm_on, cond, flt;
  logic [11:0] otoff_ff, ocoff_ff, fsl_ff, cmdp_ff;
  logic [11:0] nxt_otoff, nxt_ocoff, nxt_fsl, nxt_stat, nxt_out;
  logic [3:0]  hs_rt;

  for (genvar i = 0; i < `WDFS_NOUT; i++) begin : g_out
    logic ot_det;
    assign ot_det = ot_s[i] & out_ff[i]; // R18
    if (i < `WDFS_NHS) begin : g_hs
      logic ol_raw;
      assign ol_raw       = ol_s[i] & ~out_ff[i] & ~olc_ff[i]; // R12
      assign dir_on[i]    = ihs_s[i]; // R11
      assign nxt_otoff[i] = ot_det | (otoff_ff[i] & ot_s[i]); // R20
      assign nxt_ocoff[i] = 1'b0; // R13
      assign nxt_fsl[i]   = 1'b0;
      assign hs_rt[i]     = ol_raw | ot_det | otoff_ff[i]; // R16
      assign cond[i]      = ol_raw | ot_det;
      assign flt[i]       = ol_raw | ot_det;
    end else begin : g_ls
      logic [`WDFS_FILT_W-1:0] filt_ff;
      logic                    oc_raw, ol_raw, hit, ocf, olf, tog;
      assign oc_raw = oc_s[i-`WDFS_NHS] & out_ff[i] & occ_ff[i]; // R13
      assign ol_raw = ol_s[i] & ~out_ff[i] & olc_ff[i]; // R12
      assign hit    = (oc_raw | ol_raw) & (filt_ff == FILT_CYC);
      assign ocf    = hit & out_ff[i];
      assign olf    = hit & ~out_ff[i];
      assign tog    = cmd_on[i] ^ cmdp_ff[i];

      // Transients shorter than the filter never reach the fault logic.
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          filt_ff <= '0;
        end else if (!(oc_raw || ol_raw)) begin // R14
          filt_ff <= '0;
        end else if (filt_ff != FILT_CYC) begin
          filt_ff <= filt_ff + `WDFS_FILT_W'(1);
        end
      end

      assign dir_on[i]    = ils_s; // R11
      // Stays off after cooling until the command itself goes off.
      assign nxt_otoff[i] = ot_det | (otoff_ff[i] & (ot_s[i] | cmd_on[i])); // R19
      assign nxt_ocoff[i] = ocf | (ocoff_ff[i] & cmd_on[i]);
      assign nxt_fsl[i]   = ot_det | ocf | olf | (fsl_ff[i] & ~tog & rstp_s); // R17
      assign cond[i]      = oc_raw | ol_raw | ot_det;
      assign flt[i]       = ot_det | ocf | olf;
    end
    assign cmd_on[i]   = sel_ff[i] ? cmd_ff[i] : dir_on[i]; // R9
    assign norm_on[i]  = cmd_on[i] & ~otoff_ff[i] & ~ocoff_ff[i]; // R18
    // A new fault beats a clear in the same cycle.
    assign nxt_stat[i] = flt[i] | ov_s | (stat_ff[i] & ~(cs_rise & ~cond[i] & ~ov_s)); // R15 R21
  end

  // Mode table.
  always_comb begin
    if (fs_ff) begin
      nxt_mode = WDFS_FAILSAFE;
    end else if (!rstp_s && !wake_s) begin
      nxt_mode = WDFS_SLEEP;
    end else if (!rstp_s) begin
      nxt_mode = WDFS_HOLD;
    end else begin
      nxt_mode = WDFS_NORMAL;
    end
  end

  // Output selection; overvoltage overrides every mode.
  always_comb begin
    case (nxt_mode)
      WDFS_FAILSAFE: nxt_out = `WDFS_FS_ON; // R4
      WDFS_SLEEP:    nxt_out = `WDFS_OUT_RST; // R7
      WDFS_HOLD:     nxt_out = `WDFS_OUT_RST; // R8
      WDFS_NORMAL:   nxt_out = norm_on; // R9
      default:       nxt_out = `WDFS_OUT_RST;
    endcase
    if (ov_s) begin
      nxt_out = `WDFS_OUT_RST; // R21
    end
  end

  // Fault state and output registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      otoff_ff  <= `WDFS_OUT_RST;
      ocoff_ff  <= `WDFS_OUT_RST;
      fsl_ff    <= `WDFS_OUT_RST;
      cmdp_ff   <= `WDFS_OUT_RST;
      stat_ff   <= `WDFS_OUT_RST;
      out_ff    <= `WDFS_OUT_RST;
      mode_ff   <= WDFS_SLEEP;
      flag_n_ff <= 1'b1;
    end else begin
      otoff_ff  <= nxt_otoff;
      ocoff_ff  <= nxt_ocoff;
      fsl_ff    <= nxt_fsl;
      cmdp_ff   <= cmd_on;
      stat_ff   <= nxt_stat;
      out_ff    <= nxt_out;
      mode_ff   <= nxt_mode;
      flag_n_ff <= ~(ov_s | (|hs_rt) | (|nxt_fsl)); // R16 R17
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign output_on        = out_ff;
  assign fault_flag_pin_n = flag_n_ff;
  assign failsafe_active  = fs_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wd_start_a: assert property (wd_start && fsi_s && rstp_s |=> wd_en_ff && wd_cnt_ff == 32'h0) // R1
    else $error("watchdog not started on pin rise");
  wd_refresh_a: assert property (wd_en_ff && wd_refresh |=> wd_cnt_ff == 32'h0) // R2
    else $error("watchdog count not restarted by refresh");
  fs_enter_a: assert property (expired && fsi_s && !fs_exit |=> fs_ff) // R3
    else $error("fail-safe not entered on expiry");
  fs_force_a: assert property (fs_ff && !ov_s |=> out_ff == `WDFS_FS_ON) // R4
    else $error("fail-safe outputs wrong");
  fs_exit_a: assert property (fs_ff && !rstp_s && !wake_s |=> !fs_ff ##1 !fs_ff) // R5
    else $error("fail-safe not left in sleep");
  fsi_off_a: assert property (!fsi_s |=> !fs_ff && !wd_en_ff) // R6
    else $error("watchdog active while disabled");
  hold_off_a: assert property (!fs_ff && !rstp_s |=> out_ff == `WDFS_OUT_RST) // R7
    else $error("outputs on while reset pin low");
  stat_keep_a: assert property (!cs_rise |=> (stat_ff & $past(stat_ff)) == $past(stat_ff)) // R15
    else $error("status bit cleared without chip select rise");
  ov_all_a: assert property (ov_s |=> out_ff == `WDFS_OUT_RST && &stat_ff && !flag_n_ff) // R21
    else $error("overvoltage handling wrong");
  cfg_zero_a: assert property (!rstp_s |=> cmd_ff == `WDFS_OUT_RST && sel_ff == `WDFS_OUT_RST) // R10
    else $error("configuration not cleared by reset pin");
  apb_ready_a: assert property (setup |=> pready_ff ##1 !pready_ff)
    else $error("apb answer timing wrong");

  fs_enter_c: cover property (!fs_ff ##1 fs_ff);
  fs_leave_c: cover property (fs_ff ##1 !fs_ff);
  ov_event_c: cover property (ov_s ##1 !ov_s);
  apb_write_c: cover property (wr && paddr == `WDFS_CFG_OFS);

endmodule

/* dv/wdfs_host.sv */
// Host-side model that refreshes the watchdog and strobes chip select.
module wdfs_host #(
  parameter int unsigned PERIOD = 16
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Requests from the bench.
  input  wire logic refresh_on,
  input  wire logic cs_req,
  // Pins toward the device.
  output logic      watchdog_refresh_pin,
  output logic      chip_select_n
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] cnt_ff;

  // ---------------------------------------------------------------------------
  // Watchdog refresh
  // ---------------------------------------------------------------------------
  // Toggles well inside the shortened timeout, so a healthy host never lets it run out.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff               <= 8'h00;
      watchdog_refresh_pin <= 1'b0;
    end else if (cnt_ff == 8'(PERIOD - 1)) begin
      cnt_ff <= 8'h00;
      if (refresh_on) begin
        watchdog_refresh_pin <= !watchdog_refresh_pin;
      end
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Chip select
  // ---------------------------------------------------------------------------
  // Select is held low while the bench asks; its release gives the clearing edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chip_select_n <= 1'b1;
    end else begin
      chip_select_n <= !cs_req;
    end
  end
endmodule

/* dv/test_watchdog_failsafe_fault_supervisor.sv */
// Self-checking bench for the watchdog, fail-safe and fault supervisor.
module test_watchdog_failsafe_fault_supervisor;
  timeunit 1ns;
  timeprecision 100ps;
  import wdfs_pkg::*;

  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, wake_in, reset_pin_n;
  logic refresh_on, cs_req, watchdog_refresh_pin, failsafe_disable_input, chip_select_n;
  logic low_side_direct_input, overvoltage_sense, fault_flag_pin_n, failsafe_active, slv_q;
  logic [7:0]  paddr, overcurrent_sense;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  high_side_direct_input;
  logic [11:0] overtemp_sense, open_load_sense, output_on;
  int errors, n_compared;

  wdfs_top #(.BASE_TO_CYC(64)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_in(wake_in), .reset_pin_n(reset_pin_n), .watchdog_refresh_pin(watchdog_refresh_pin),
    .failsafe_disable_input(failsafe_disable_input), .chip_select_n(chip_select_n),
    .low_side_direct_input(low_side_direct_input), .high_side_direct_input(high_side_direct_input),
    .overvoltage_sense(overvoltage_sense), .overtemp_sense(overtemp_sense), .open_load_sense(open_load_sense),
    .overcurrent_sense(overcurrent_sense), .output_on(output_on), .fault_flag_pin_n(fault_flag_pin_n),
    .failsafe_active(failsafe_active));
  wdfs_host host (.clk_sys(clk_sys), .rst_n(rst_n), .refresh_on(refresh_on), .cs_req(cs_req),
    .watchdog_refresh_pin(watchdog_refresh_pin), .chip_select_n(chip_select_n));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("errors %0d n_compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Waits n rising edges, then settles at the falling edge so outputs are stable to read.
  task automatic nx(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // One APB transfer; pready, read data and error are taken at the rising edge that ends the access.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        $display("FAIL %0t apb timeout", $time);
        complete_run();
      end
      @(posedge clk_sys);
    end
    r       = prdata;
    slv_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wfs(input logic v, input int lim);
    int n;
    n = 0;
    while (failsafe_active !== v) begin
      n++;
      if (n > lim) begin
        errors++;
        $display("FAIL %0t fail-safe wait", $time);
        complete_run();
      end
      @(negedge clk_sys);
    end
  endtask

  task automatic cs_pulse();
    @(posedge clk_sys);
    cs_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cs_req <= 1'b0;
    nx(6);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, wake_in, cs_req, overvoltage_sense} = '0;
    {overtemp_sense, open_load_sense, overcurrent_sense, high_side_direct_input} = '0;
    {rst_n, reset_pin_n, refresh_on, failsafe_disable_input, low_side_direct_input} = 5'b01111;
    high_side_direct_input = 4'h9;
    errors = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    nx(6);
    chk(output_on, 12'hff9, "default outputs");
    apb(1'b0, `WDFS_CFG_OFS, 32'h0, q);
    chk(q, 32'h0, "cfg reset");
    apb(1'b0, 8'h1c, 32'h0, q);
    chk(q, 32'h0, "unmapped data");
    chk({31'h0, slv_q}, 32'h1, "unmapped error");
    // Off-state open load: high side reported live, low side ignored while unconfigured.
    @(posedge clk_sys);
    {low_side_direct_input, high_side_direct_input} <= 5'h0;
    open_load_sense <= 12'h042;
    nx(250);
    chk(fault_flag_pin_n, 1'b0, "hs open load flag");
    apb(1'b0, `WDFS_STAT_OFS, 32'h0, q);
    chk(q & 32'hfff, 32'h002, "default open load");
    @(posedge clk_sys);
    open_load_sense <= 12'h000;
    nx(5);
    chk(fault_flag_pin_n, 1'b1, "flag follows live");
    cs_pulse();
    // Serial control and overvoltage.
    apb(1'b1, `WDFS_SEL_OFS, 32'hfff, q);
    apb(1'b1, `WDFS_CMD_OFS, 32'h0a5, q);
    nx(2);
    chk(output_on, 12'h0a5, "serial outputs");
    @(posedge clk_sys);
    overvoltage_sense <= 1'b1;
    nx(5);
    chk({output_on, fault_flag_pin_n}, 13'h0, "overvoltage off");
    @(posedge clk_sys);
    overvoltage_sense <= 1'b0;
    nx(5);
    chk(output_on, 12'h0a5, "overvoltage ends");
    apb(1'b0, `WDFS_STAT_OFS, 32'h0, q);
    chk(q & 32'hfff, 32'hfff, "overvoltage latched");
    cs_pulse();
    apb(1'b0, `WDFS_STAT_OFS, 32'h0, q);
    chk(q & 32'hfff, 32'h0, "cleared on cs rise");
    // Low-side overcurrent on output 5 is filtered, then latches off.
    apb(1'b1, `WDFS_OCC_OFS, 32'h020, q);
    @(posedge clk_sys);
    overcurrent_sense <= 8'h02;
    nx(150);
    chk(output_on, 12'h0a5, "filter holds");
    nx(100);
    chk({output_on, fault_flag_pin_n}, {12'h085, 1'b0}, "overcurrent off");
    @(posedge clk_sys);
    overcurrent_sense <= 8'h00;
    apb(1'b1, `WDFS_CMD_OFS, 32'h085, q);
    apb(1'b1, `WDFS_CMD_OFS, 32'h0a5, q);
    nx(2);
    chk({output_on, fault_flag_pin_n}, {12'h0a5, 1'b1}, "toggle clears");
    // High side recovers alone, low side waits for an off command.
    @(posedge clk_sys);
    overtemp_sense <= 12'h081;
    nx(5);
    chk(output_on, 12'h024, "local shutdown");
    @(posedge clk_sys);
    overtemp_sense <= 12'h000;
    nx(5);
    chk(output_on, 12'h025, "hs back, ls held");
    apb(1'b1, `WDFS_CMD_OFS, 32'h025, q);
    apb(1'b1, `WDFS_CMD_OFS, 32'h0a5, q);
    nx(2);
    chk(output_on, 12'h0a5, "ls on again");
    // Full timeout: a halved count would already have expired at 45 cycles.
    @(posedge clk_sys);
    refresh_on <= 1'b0;
    nx(5);
    apb(1'b1, `WDFS_CFG_OFS, 32'h8000, q);
    nx(45);
    chk(failsafe_active, 1'b0, "full timeout");
    wfs(1'b1, 40);
    nx(3);
    chk(output_on, `WDFS_FS_ON, "fail-safe outputs");
    @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    wfs(1'b0, 10);
    nx(2);
    chk(output_on, 12'h000, "sleep outputs");
    @(posedge clk_sys);
    refresh_on  <= 1'b1;
    reset_pin_n <= 1'b1;
    nx(5);
    apb(1'b0, `WDFS_SEL_OFS, 32'h0, q);
    chk(q, 32'h0, "default after exit");
    // Eighth timeout with wake raised: reset low alone no longer exits.
    @(posedge clk_sys);
    wake_in <= 1'b1;
    nx(5);
    @(posedge clk_sys);
    refresh_on <= 1'b0;
    nx(5);
    apb(1'b1, `WDFS_CFG_OFS, 32'h0030, q);
    nx(2);
    chk(failsafe_active, 1'b0, "restart on divider");
    wfs(1'b1, 20);
    @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    nx(10);
    chk({failsafe_active, output_on}, {1'b1, `WDFS_FS_ON}, "wake keeps fail-safe");
    @(posedge clk_sys);
    wake_in <= 1'b0;
    wfs(1'b0, 10);
    // Disable input grounded: no refresh and still no fail-safe.
    @(posedge clk_sys);
    failsafe_disable_input <= 1'b0;
    reset_pin_n            <= 1'b1;
    nx(150);
    chk(failsafe_active, 1'b0, "watchdog disabled");
    complete_run();
  end
endmodule
